// ---- logic/fifo_host.sv ----
// ----------------------------------------------------------------
// Wishbone-driven controller for an external strobe FIFO
// ----------------------------------------------------------------
// Summary of operation
// - Host ties chain_head_n low on first device, high otherwise.
// - Composite full and empty flags are ORed across the chain.
// - Width expansion: status may be taken from any one device.
// - Writer strobes push only while full_n is high.
// - Writer watches full_n, reader watches empty_n.
// - Push starts on falling strobe; data held across rising edge.
// - Clear after power-up with both strobes high at its release.
// - Replay pulse rewinds read pointer; strobes stay high.
module fifo_host #(
  parameter int DATA_W = fifo_host_pkg::DATA_W,
  parameter int DEPTH = fifo_host_pkg::DEPTH_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic push_pulse_n_o,
  output logic [DATA_W-1:0] push_data_o,
  output logic pop_pulse_n_o,
  input wire logic [DATA_W-1:0] pop_data_i,
  output logic clear_n_o,
  output logic replay_n_o,
  output logic chain_in_n_o,
  output logic chain_head_n_o,
  input wire logic full_n_i,
  input wire logic empty_n_i,
  input wire logic half_n_i
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] flag_s1_reg;
  logic [2:0] flag_s2_reg;
  logic [DATA_W-1:0] pd_s1_reg;
  logic [DATA_W-1:0] pd_s2_reg;

  // Flags come from one device; a chain's composite flags are ORed
  // on the board before they reach these pins
  always_ff @(posedge clk_i) begin
    flag_s1_reg <= {half_n_i, empty_n_i, full_n_i};
    flag_s2_reg <= flag_s1_reg;
    pd_s1_reg <= pop_data_i;
    pd_s2_reg <= pd_s1_reg;
  end

  wire full_n_s = flag_s2_reg[0];
  wire empty_n_s = flag_s2_reg[1];
  wire half_n_s = flag_s2_reg[2];

  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  // One-hot sequencer; every pulse is followed by a recover gap
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PUSH = 6'h02,
    ST_POP = 6'h04,
    ST_CLEAR = 6'h08,
    ST_REPLAY = 6'h10,
    ST_RECOVER = 6'h20
  } seq_t;

  seq_t state_reg;
  seq_t state_next;
  logic [7:0] cnt_reg;
  logic [3:0] ctrl_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic pvalid_reg;
  logic refused_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic push_n_reg;
  logic pop_n_reg;
  logic clear_n_reg;
  logic replay_n_reg;

  // The registered ack masks the held strobe, so one request per access
  wire req = cyc_i && stb_i && !ack_reg;
  wire wr = req && we_i;
  wire rd = req && !we_i;
  wire hit_ctrl = adr_i == fifo_host_pkg::CTRL_OFS;
  wire hit_push = adr_i == fifo_host_pkg::PUSH_OFS;
  wire hit_pop = adr_i == fifo_host_pkg::POP_OFS;
  wire hit_stat = adr_i == fifo_host_pkg::STAT_OFS;
  wire idle = state_reg == ST_IDLE;
  wire depth_mode = ctrl_reg[fifo_host_pkg::CTRL_CHAIN_BIT];
  wire cnt_done = cnt_reg == 8'h00;
  // A sequence request while busy is acked but refused and flagged.
  wire start_push = wr && hit_push && sel_i[0] && sel_i[1];
  wire start_pop = wr && hit_pop;
  wire start_clear = wr && hit_ctrl && sel_i[0] &&
                     dat_i[fifo_host_pkg::CTRL_CLEAR_BIT];
  wire start_replay = wr && hit_ctrl && sel_i[0] &&
                      dat_i[fifo_host_pkg::CTRL_REPLAY_BIT] && !depth_mode;
  wire any_start = start_push || start_pop || start_clear || start_replay;
  // Only strobe when the blocking flag allows it
  // Flags lag two cycles, so a start right after a pop may be refused
  wire push_ok = full_n_s;
  wire pop_ok = empty_n_s;
  wire go_push = idle && start_push && push_ok;
  wire go_pop = idle && start_pop && pop_ok;
  wire refuse = any_start && !(go_push || go_pop ||
                (idle && (start_clear || start_replay)));

  // Clear and replay take priority; a busy sequencer starts nothing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start_clear) begin
          state_next = ST_CLEAR;
        end else if (start_replay) begin
          state_next = ST_REPLAY;
        end else if (go_push) begin
          state_next = ST_PUSH;
        end else if (go_pop) begin
          state_next = ST_POP;
        end
      end
      ST_PUSH, ST_POP, ST_CLEAR, ST_REPLAY: begin
        if (cnt_done) begin
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (cnt_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Counts run one short since the entry edge already opens the pulse
  wire [7:0] pulse_len = 8'(fifo_host_pkg::PULSE_CYC - 1);
  wire [7:0] rec_len = 8'(fifo_host_pkg::RECOVER_CYC - 1);
  wire entering = state_next != state_reg;
  wire [7:0] cnt_next = !entering ? (cnt_done ? 8'h00 : cnt_reg - 8'h01)
                        : (state_next == ST_RECOVER ? rec_len : pulse_len);
  wire in_push = state_next == ST_PUSH;
  wire in_pop = state_next == ST_POP;
  // Sample pop data in the last low cycle, before the strobe rises
  wire pop_sample = state_reg == ST_POP && cnt_done;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Pins: every strobe and level comes from a flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_n_reg <= 1'b1;
      pop_n_reg <= 1'b1;
    end else begin
      push_n_reg <= !in_push;
      pop_n_reg <= !in_pop;
    end
  end

  // Other strobes are high here since sequences never overlap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clear_n_reg <= 1'b1;
      replay_n_reg <= 1'b1;
    end else begin
      clear_n_reg <= state_next != ST_CLEAR;
      replay_n_reg <= state_next != ST_REPLAY;
    end
  end

  // ----------------------------------------------------------------
  // Read-back selection
  // ----------------------------------------------------------------
  // Flags are shown active high and lag the pins by the sync flops
  wire [31:0] ctrl_word = {28'h0, ctrl_reg};
  wire [31:0] push_word = 32'(wdata_reg);
  wire [31:0] pop_word = 32'(rdata_reg);
  wire [31:0] stat_word = {26'h0, pvalid_reg, refused_reg, !idle,
                           !half_n_s, !empty_n_s, !full_n_s};
  wire [31:0] rdata_mux = !rd ? 32'h0000_0000 :
                          hit_ctrl ? ctrl_word :
                          hit_push ? push_word :
                          hit_pop ? pop_word :
                          hit_stat ? stat_word : 32'h0000_0000;
  wire ctrl_wr = wr && hit_ctrl && sel_i[0];
  wire pop_rd = rd && hit_pop;
  wire stat_rd = rd && hit_stat;

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Registered ack: every access takes exactly one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      dat_reg <= rdata_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control levels
  // ----------------------------------------------------------------
  // Clear and replay bits are strobes and are never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= fifo_host_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg[fifo_host_pkg::CTRL_CHAIN_BIT] <=
        dat_i[fifo_host_pkg::CTRL_CHAIN_BIT];
      ctrl_reg[fifo_host_pkg::CTRL_HEAD_BIT] <=
        dat_i[fifo_host_pkg::CTRL_HEAD_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Data words
  // ----------------------------------------------------------------
  // Push data is held from the strobe's fall past its rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdata_reg <= '0;
    end else if (go_push) begin
      wdata_reg <= dat_i[DATA_W-1:0];
    end
  end

  // A new word wins over the read that would clear the valid bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
      pvalid_reg <= 1'b0;
    end else if (pop_sample) begin
      rdata_reg <= pd_s2_reg;
      pvalid_reg <= 1'b1;
    end else if (pop_rd) begin
      pvalid_reg <= 1'b0;
    end
  end

  // A refusal in the cycle of a status read stays visible
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused_reg <= 1'b0;
    end else if (refuse) begin
      refused_reg <= 1'b1;
    end else if (stat_rd) begin
      refused_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every pin below is a flip-flop, so no glitch reaches the part
  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign push_pulse_n_o = push_n_reg;
  assign push_data_o = wdata_reg;
  assign pop_pulse_n_o = pop_n_reg;
  assign clear_n_o = clear_n_reg;
  assign replay_n_o = replay_n_reg;
  assign chain_in_n_o = ctrl_reg[fifo_host_pkg::CTRL_CHAIN_BIT];
  assign chain_head_n_o = ctrl_reg[fifo_host_pkg::CTRL_HEAD_BIT];
endmodule : fifo_host

// ---- common/fifo_host_pkg.sv ----
package fifo_host_pkg;
  // ----------------------------------------------------------------
  // Register map (byte offsets on the Wishbone side)
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] PUSH_OFS = 4'h4;
  localparam logic [3:0] POP_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hc;
  // CTRL fields
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_REPLAY_BIT = 1;
  localparam int CTRL_CHAIN_BIT = 2;
  localparam int CTRL_HEAD_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // STAT fields
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int STAT_HALF_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_REFUSED_BIT = 4;
  localparam int STAT_PVALID_BIT = 5;
  // ----------------------------------------------------------------
  // Strobe timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int PULSE_NS = 60;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_NS = 40;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEPTH_DEFAULT = 512;
  localparam int DATA_W = 9;
endpackage : fifo_host_pkg

// ---- verif/fifo_dev_model.sv ----
module fifo_dev_model #(
  parameter int DEPTH = 8
) (
  input wire logic push_n_i,
  input wire logic [8:0] d_i,
  input wire logic pop_n_i,
  output logic [8:0] q_o,
  input wire logic clear_n_i,
  input wire logic replay_n_i,
  input wire logic chain_in_n_i,
  output logic full_n_o,
  output logic empty_n_o,
  output logic half_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] mem [DEPTH];
  logic [8:0] q_reg = 9'h0;
  logic half_reg = 1'b1;
  int wp = 0;
  int rp = 0;
  bit wr_ok, rd_ok;
  assign full_n_o = (wp - rp) != DEPTH;
  assign empty_n_o = wp != rp;
  assign half_n_o = half_reg | chain_in_n_i;
  // Inverse, not a float, so a stale word can never pass by luck
  assign q_o = pop_n_i ? ~q_reg : q_reg;
  always @(negedge clear_n_i) begin
    wp = 0;
    rp = 0;
    half_reg = 1'b1;
  end
  // Rewinding moves the fill level, so the half flag follows it
  always @(negedge replay_n_i) begin
    if (!chain_in_n_i) begin
      rp = 0;
      half_reg = (wp - rp) <= DEPTH / 2;
    end
  end
  always @(negedge push_n_i) begin
    wr_ok = full_n_o;
    if (wr_ok && wp - rp >= DEPTH / 2) half_reg = 1'b0;
  end
  always @(posedge push_n_i) begin
    if (wr_ok) mem[wp % DEPTH] = d_i;
    if (wr_ok) wp++;
  end
  always @(negedge pop_n_i) begin
    rd_ok = empty_n_o;
    if (rd_ok) q_reg = mem[rp % DEPTH];
  end
  always @(posedge pop_n_i) begin
    if (rd_ok) rp++;
    if (rd_ok && wp - rp <= DEPTH / 2) half_reg = 1'b1;
  end
endmodule : fifo_dev_model

// ---- verif/fifo_host_chk.sv ----
module fifo_host_chk #(
  parameter int DATA_W = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic push_pulse_n_o,
  input wire logic [DATA_W-1:0] push_data_o,
  input wire logic pop_pulse_n_o,
  input wire logic clear_n_o,
  input wire logic replay_n_o,
  input wire logic chain_in_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_low3(sig);
    !sig [*3] ##1 sig;
  endsequence
  sequence s_quiet;
    push_pulse_n_o && pop_pulse_n_o;
  endsequence
  a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  a_push_width: assert property (
    $fell(push_pulse_n_o) |-> s_low3(push_pulse_n_o))
    else $error("push strobe width");
  a_pop_width: assert property (
    $fell(pop_pulse_n_o) |-> s_low3(pop_pulse_n_o))
    else $error("pop strobe width");
  a_clear_width: assert property (
    $fell(clear_n_o) |-> s_low3(clear_n_o))
    else $error("clear width");
  a_push_hold: assert property (
    (!push_pulse_n_o && !$fell(push_pulse_n_o)) || $rose(push_pulse_n_o)
    |-> $stable(push_data_o)) else $error("push data moved");
  a_clear_quiet: assert property (
    $fell(clear_n_o) |-> s_quiet [*6]) else $error("strobe in clear");
  a_replay_quiet: assert property (
    $fell(replay_n_o) |-> s_quiet [*6]) else $error("strobe in replay");
  a_replay_single: assert property (
    !replay_n_o |-> !chain_in_n_o) else $error("replay in chain mode");
endmodule : fifo_host_chk
bind fifo_host fifo_host_chk #(.DATA_W(DATA_W)) fifo_host_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .push_pulse_n_o(push_pulse_n_o),
  .push_data_o(push_data_o), .pop_pulse_n_o(pop_pulse_n_o),
  .clear_n_o(clear_n_o), .replay_n_o(replay_n_o),
  .chain_in_n_o(chain_in_n_o)
);

// ---- verif/fifo_host_bench.sv ----
module fifo_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 8;
  localparam logic [3:0] CTRL = fifo_host_pkg::CTRL_OFS;
  localparam logic [3:0] PUSH = fifo_host_pkg::PUSH_OFS;
  localparam logic [3:0] POP = fifo_host_pkg::POP_OFS;
  localparam logic [3:0] STAT = fifo_host_pkg::STAT_OFS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q, rnd;
  logic ack_o, push_n, pop_n, clear_n, replay_n, chain_in_n, chain_head_n;
  logic full_n, empty_n, half_n, ref_seen;
  logic [8:0] push_data, pop_data;
  logic [8:0] words [DEPTH];
  int errors = 0;
  int compares = 0;
  always #10 clk_i = ~clk_i;
  fifo_host #(.DEPTH(DEPTH)) fifo_host_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .push_pulse_n_o(push_n),
    .push_data_o(push_data), .pop_pulse_n_o(pop_n), .pop_data_i(pop_data),
    .clear_n_o(clear_n), .replay_n_o(replay_n), .chain_in_n_o(chain_in_n),
    .chain_head_n_o(chain_head_n), .full_n_i(full_n), .empty_n_i(empty_n),
    .half_n_i(half_n));
  fifo_dev_model #(.DEPTH(DEPTH)) fifo_dev_model_inst (.push_n_i(push_n),
    .d_i(push_data), .pop_n_i(pop_n), .q_o(pop_data), .clear_n_i(clear_n),
    .replay_n_i(replay_n), .chain_in_n_i(chain_in_n), .full_n_o(full_n),
    .empty_n_o(empty_n), .half_n_o(half_n));
  task automatic tally_and_finish;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_word(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) errors++;
    if (got !== exp) $display("ERROR %s expected %h seen %h", what, exp, got);
  endtask : cmp_word
  task automatic cmp_flag(input string what, input logic exp, got);
    compares++;
    if (got !== exp) errors++;
    if (got !== exp) $display("ERROR %s expected %b seen %b", what, exp, got);
  endtask : cmp_flag
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  // Reading status clears the refused bit, so any set bit is kept
  task automatic wait_idle;
    ref_seen = 1'b0;
    do begin
      wb(1'b0, STAT, 32'h0);
      ref_seen |= q[fifo_host_pkg::STAT_REFUSED_BIT];
    end while (q[fifo_host_pkg::STAT_BUSY_BIT] !== 1'b0);
    repeat (4) @(posedge clk_i);
  endtask : wait_idle
  function automatic logic [31:0] stat_exp(input int n);
    return {29'h0, n > DEPTH / 2, n == 0, n == DEPTH};
  endfunction : stat_exp
  task automatic chk_stat(input int n);
    wb(1'b0, STAT, 32'h0);
    cmp_word("stat", stat_exp(n), q & 32'h7);
  endtask : chk_stat
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(46));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL, 32'h0);
    cmp_word("ctrl", 32'(fifo_host_pkg::CTRL_RESET), q);
    wb(1'b0, 4'h6, 32'h0);
    cmp_word("unmapped", 32'h0, q);
    wb(1'b1, CTRL, 32'h1);
    wait_idle;
    chk_stat(0);
    for (int i = 0; i <= DEPTH; i++) begin
      rnd = $urandom;
      if (i < DEPTH) words[i] = rnd[8:0];
      wb(1'b1, PUSH, rnd);
      wait_idle;
      cmp_flag("push refused", i == DEPTH, ref_seen);
      chk_stat(i < DEPTH ? i + 1 : DEPTH);
    end
    wb(1'b0, PUSH, 32'h0);
    cmp_word("push echo", 32'(words[DEPTH-1]), q);
    for (int i = 0; i <= DEPTH; i++) begin
      wb(1'b1, POP, 32'h0);
      wait_idle;
      cmp_flag("pop refused", i == DEPTH, ref_seen);
      wb(1'b0, POP, 32'h0);
      if (i < DEPTH) cmp_word("pop data", 32'(words[i]), q);
      chk_stat(i < DEPTH ? DEPTH - 1 - i : 0);
    end
    wb(1'b1, CTRL, 32'h2);
    wait_idle;
    chk_stat(DEPTH);
    wb(1'b1, POP, 32'h0);
    wait_idle;
    wb(1'b0, POP, 32'h0);
    cmp_word("replay data", 32'(words[0]), q);
    wb(1'b1, PUSH, 32'h1a5);
    wait_idle;
    chk_stat(DEPTH);
    wb(1'b1, CTRL, 32'hc);
    cmp_flag("chain_in_n", 1'b1, chain_in_n);
    cmp_flag("chain_head_n", 1'b1, chain_head_n);
    wb(1'b1, CTRL, 32'he);
    cmp_flag("replay_n", 1'b1, replay_n);
    tally_and_finish;
  end
endmodule : fifo_host_bench
